/* design/adc_mode_sequencer.sv */
// Successive approximation converter mode sequencer with AHB-Lite registers
// Function
// R1 - Control write mid-conversion flagged, result undefined
// R2 - Software reprograms channel after mode change
// R3 - Software keeps converter clock below 10 MHz
// R4 - Writing start one begins conversion
// R5 - Writing start zero stops conversion
// R6 - One-shot converts selected channel exactly once
// R7 - One-shot and sweep end clear start; the code keeps start set at the end when trigger select is on
// R8 - One-shot and single sweep end interrupt
// R9 - Channel field picks input 0 to 7
// R10 - Repeat converts continuously, no interrupt
// R11 - Results readable anytime during conversion
// R12 - Single sweep converts group once, ends
// R13 - Group select gives 2, 4, 6, 8
// R14 - Repeat sweep loops group, no interrupt
// R15 - Conversion takes 49 or 59 ticks
// R16 - Low 8 bits even byte, upper odd
// R17 - Trigger falling edge starts, retriggers conversion
// R18 - Sweep ascends from input 0, storing each
// R19 - Start flag held in repeating modes
`timescale 1ns/1ps
module adc_mode_sequencer
  import adc_seq_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  input wire logic external_trigger_input,
  input wire logic cmp_high,
  output logic [CH_W-1:0] analog_sel,
  output logic sample_en,
  output logic [RES_W-1:0] dac_code,
  output logic converter_clock
);

  // ****************************************
  // Bus slave
  // ****************************************
  logic addr_ok;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic rd_mem_ff;
  logic [31:0] rd_data_ff;
  logic [31:0] nxt_rd_data;
  logic [RES_W-1:0] mem_q;
  logic wr_ctrl;
  logic wr_ien;
  logic wr_iclr;

  // Control and status state
  mode_t mode_ff;
  logic [CH_W-1:0] ch_sel_ff;
  logic [1:0] grp_ff;
  logic start_ff;
  logic trig_sel_ff;
  logic res10_ff;
  logic [1:0] div_ff;
  logic [STAT_W-1:0] stat_ff;
  logic [STAT_W-1:0] ien_ff;
  logic [STAT_W-1:0] evt;

  // Engine state
  state_t state_ff;
  state_t nxt_state;
  logic [CH_W-1:0] cur_ch_ff;
  logic [6:0] tick_cnt_ff;
  logic [3:0] bit_idx_ff;
  logic [1:0] sub_ff;
  logic trial_on_ff;
  logic [RES_W-1:0] sar_ff;
  logic tick;
  logic trig_s1_ff;
  logic trig_s2_ff;
  logic trig_s3_ff;
  logic cmp_s1_ff;
  logic cmp_s2_ff;
  logic trig_fall;
  logic begin_conv;
  logic decide;
  logic done;
  logic finish;
  logic restart;
  logic last_ch;
  logic sweep_mode;
  logic [6:0] t0;
  logic [6:0] last_tick;
  logic [3:0] last_bit;
  logic [RES_W-1:0] bit_mask;
  logic [RES_W-1:0] sar_dec;
  logic [RES_W-1:0] result;
  logic [CH_W-1:0] nxt_ch;

  assign addr_ok = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_ctrl = wr_pend_ff && (wr_addr_ff == CTRL_OFS);
  assign wr_ien = wr_pend_ff && (wr_addr_ff == IEN_OFS);
  assign wr_iclr = wr_pend_ff && (wr_addr_ff == ICLR_OFS);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end
    else
    begin
      wr_pend_ff <= addr_ok && hwrite;
      wr_addr_ff <= haddr[7:0];
    end
  end

  always_comb
  begin
    nxt_rd_data = 32'h0;
    if (haddr[7:0] == CTRL_OFS)
      nxt_rd_data = {20'h0, div_ff, res10_ff, trig_sel_ff, start_ff, grp_ff, ch_sel_ff, mode_ff};
    else if (haddr[7:0] == STAT_OFS)
      nxt_rd_data = {30'h0, stat_ff};
    else if (haddr[7:0] == IEN_OFS)
      nxt_rd_data = {30'h0, ien_ff};
    else if (haddr[7:0] == BUSY_OFS)
      nxt_rd_data = {25'h0, cur_ch_ff, 1'b0, state_ff};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_data_ff <= 32'h0;
      rd_mem_ff <= 1'b0;
    end
    else if (addr_ok && !hwrite)
    begin
      rd_data_ff <= nxt_rd_data;
      rd_mem_ff <= (haddr[7:0] >= RES_BASE) && (haddr[7:0] <= RES_LAST);
    end
  end

  // Result words: low 8 bits in byte 0, upper 2 bits in byte 1
  assign hrdata = rd_mem_ff ? {22'h0, mem_q} : rd_data_ff; // R11 R16

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_ff <= MODE_ONESHOT;
      ch_sel_ff <= 3'h0;
      grp_ff <= 2'h0;
      trig_sel_ff <= 1'b0;
      res10_ff <= 1'b0;
      div_ff <= 2'h0;
    end
    else if (wr_ctrl)
    begin
      mode_ff <= mode_t'(hwdata[MODE_LSB +: 2]);
      ch_sel_ff <= hwdata[CH_LSB +: CH_W]; // R9
      grp_ff <= hwdata[GRP_LSB +: 2]; // R13
      trig_sel_ff <= hwdata[TRIG_BIT];
      res10_ff <= hwdata[RES10_BIT];
      div_ff <= hwdata[DIV_LSB +: 2];
    end
  end

  // Software write wins over the automatic clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      start_ff <= 1'b0;
    else if (wr_ctrl)
      start_ff <= hwdata[START_BIT]; // R4 R5
    else if (finish && !trig_sel_ff)
      start_ff <= 1'b0; // R7 R19
  end

  // ****************************************
  // Interrupt status, enable and clear
  // ****************************************
  assign evt[STAT_DONE_BIT] = finish; // R8
  assign evt[STAT_OVR_BIT] = wr_ctrl && (state_ff == ST_CONV); // R1

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      stat_ff <= '0;
    else if (wr_iclr)
      stat_ff <= (stat_ff & ~hwdata[STAT_W-1:0]) | evt;
    else
      stat_ff <= stat_ff | evt;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ien_ff <= '0;
    else if (wr_ien)
      ien_ff <= hwdata[STAT_W-1:0];
  end

  assign irq = |(stat_ff & ien_ff);

  // ****************************************
  // Input synchronisers
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      trig_s1_ff <= 1'b1;
      trig_s2_ff <= 1'b1;
      trig_s3_ff <= 1'b1;
      cmp_s1_ff <= 1'b0;
      cmp_s2_ff <= 1'b0;
    end
    else
    begin
      trig_s1_ff <= external_trigger_input;
      trig_s2_ff <= trig_s1_ff;
      trig_s3_ff <= trig_s2_ff;
      cmp_s1_ff <= cmp_high;
      cmp_s2_ff <= cmp_s1_ff;
    end
  end

  assign trig_fall = trig_s3_ff && !trig_s2_ff;

  // ****************************************
  // Sequencing
  // ****************************************
  assign sweep_mode = (mode_ff == MODE_SWEEP) || (mode_ff == MODE_RSWEEP);
  assign last_ch = (cur_ch_ff == {grp_ff, 1'b1}); // R13
  assign t0 = res10_ff ? SAR_T0_10 : SAR_T0_8;
  assign last_tick = res10_ff ? LAST_TICK_10 : LAST_TICK_8;
  assign last_bit = res10_ff ? LAST_BIT_10 : LAST_BIT_8;
  assign decide = (state_ff == ST_CONV) && tick && trial_on_ff && (sub_ff == DECIDE_SUB);
  assign done = decide && (bit_idx_ff == last_bit); // R15
  assign finish = done && ((mode_ff == MODE_ONESHOT) || ((mode_ff == MODE_SWEEP) && last_ch)); // R6 R12

  always_comb
  begin
    nxt_state = state_ff;
    begin_conv = 1'b0;
    restart = 1'b0;
    nxt_ch = cur_ch_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (wr_ctrl && hwdata[START_BIT])
        begin
          if (hwdata[TRIG_BIT])
            nxt_state = ST_WAIT;
          else
          begin
            nxt_state = ST_CONV; // R4
            begin_conv = 1'b1;
          end
        end
      end
      ST_WAIT:
      begin
        if (wr_ctrl && !hwdata[START_BIT])
          nxt_state = ST_IDLE; // R5
        else if (trig_fall)
        begin
          nxt_state = ST_CONV; // R17
          begin_conv = 1'b1;
        end
      end
      ST_CONV:
      begin
        if (wr_ctrl && !hwdata[START_BIT])
          nxt_state = ST_IDLE; // R5
        else if (trig_sel_ff && trig_fall)
          begin_conv = 1'b1; // R17
        else if (finish)
          nxt_state = trig_sel_ff ? ST_WAIT : ST_IDLE; // R7
        else if (done)
        begin
          restart = 1'b1; // R10 R14
          if (mode_ff != MODE_REPEAT)
            nxt_ch = last_ch ? 3'h0 : cur_ch_ff + 3'h1; // R18
        end
      end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cur_ch_ff <= 3'h0;
    else if (begin_conv)
      cur_ch_ff <= (sweep_mode && !wr_ctrl) || (wr_ctrl && hwdata[MODE_LSB + 1]) ? 3'h0
                   : (wr_ctrl ? hwdata[CH_LSB +: CH_W] : ch_sel_ff); // R9 R18
    else
      cur_ch_ff <= nxt_ch;
  end

  // ****************************************
  // Successive approximation engine
  // ****************************************
  assign bit_mask = 10'h200 >> bit_idx_ff;
  assign sar_dec = cmp_s2_ff ? sar_ff : (sar_ff & ~bit_mask);
  assign result = res10_ff ? sar_dec : {2'h0, sar_dec[9:2]};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tick_cnt_ff <= 7'h0;
      bit_idx_ff <= 4'h0;
      sub_ff <= 2'h0;
      trial_on_ff <= 1'b0;
      sar_ff <= 10'h0;
    end
    else if (begin_conv || restart || state_ff != ST_CONV)
    begin
      tick_cnt_ff <= 7'h0;
      bit_idx_ff <= 4'h0;
      sub_ff <= 2'h0;
      trial_on_ff <= 1'b0;
      sar_ff <= 10'h0;
    end
    else if (tick)
    begin
      tick_cnt_ff <= tick_cnt_ff + 7'h1;
      if (!trial_on_ff && tick_cnt_ff == t0)
      begin
        trial_on_ff <= 1'b1;
        sar_ff <= 10'h200;
      end
      else if (decide)
      begin
        sub_ff <= 2'h0;
        bit_idx_ff <= bit_idx_ff + 4'h1;
        sar_ff <= sar_dec | (bit_mask >> 1);
      end
      else if (trial_on_ff)
        sub_ff <= sub_ff + 2'h1;
    end
  end

  assign analog_sel = cur_ch_ff;
  assign sample_en = (state_ff == ST_CONV) && !trial_on_ff;
  assign dac_code = sar_ff;

  conv_clk_div u_div
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .div_sel(div_ff),
    .tick(tick)
  );

  assign converter_clock = tick;

  result_mem u_mem
  (
    .hclk(hclk),
    .we(done && !(wr_ctrl && !hwdata[START_BIT])),
    .waddr(cur_ch_ff),
    .wdata(result),
    .raddr(haddr[4:2]),
    .rdata_ff(mem_q)
  );

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_start;
    (state_ff == ST_IDLE) && wr_ctrl && hwdata[START_BIT] && !hwdata[TRIG_BIT] |=> state_ff == ST_CONV;
  endproperty
  a_start: assert property (p_start) else $error("start write did not begin conversion"); // R4

  property p_stop;
    wr_ctrl && !hwdata[START_BIT] |=> (state_ff == ST_IDLE) && !start_ff;
  endproperty
  a_stop: assert property (p_stop) else $error("stop write did not stop conversion"); // R5

  property p_autoclr;
    finish && !trig_sel_ff && !wr_ctrl |=> !start_ff && (state_ff == ST_IDLE);
  endproperty
  a_autoclr: assert property (p_autoclr) else $error("start flag not cleared at end"); // R7

  property p_irq;
    finish && !wr_iclr |=> stat_ff[STAT_DONE_BIT];
  endproperty
  a_irq: assert property (p_irq) else $error("done status not raised"); // R8

  property p_noirq;
    ((mode_ff == MODE_REPEAT) || (mode_ff == MODE_RSWEEP)) && (state_ff == ST_CONV) && !stat_ff[STAT_DONE_BIT]
      |=> !stat_ff[STAT_DONE_BIT];
  endproperty
  a_noirq: assert property (p_noirq) else $error("repeating mode raised completion"); // R10

  property p_len;
    done |-> tick_cnt_ff == last_tick;
  endproperty
  a_len: assert property (p_len) else $error("conversion length wrong"); // R15

  property p_order;
    done && sweep_mode && !last_ch && !wr_ctrl && !(trig_sel_ff && trig_fall) |=> cur_ch_ff == $past(cur_ch_ff) + 3'h1;
  endproperty
  a_order: assert property (p_order) else $error("sweep not ascending"); // R18

  property p_hold;
    start_ff && !sweep_mode && (mode_ff == MODE_REPEAT) && !wr_ctrl |=> start_ff;
  endproperty
  a_hold: assert property (p_hold) else $error("start flag dropped in repeat"); // R19

  property p_trig;
    (state_ff == ST_WAIT) && trig_fall && !wr_ctrl |=> (state_ff == ST_CONV) && (tick_cnt_ff == 7'h0);
  endproperty
  a_trig: assert property (p_trig) else $error("trigger did not start conversion"); // R17

  property p_group;
    (state_ff == ST_CONV) && sweep_mode |-> cur_ch_ff <= {grp_ff, 1'b1};
  endproperty
  a_group: assert property (p_group) else $error("sweep channel outside group"); // R13

  property p_res8;
    done && !res10_ff |-> result[9:8] == 2'h0;
  endproperty
  a_res8: assert property (p_res8) else $error("8-bit result has upper bits"); // R16

  c_oneshot: cover property (finish && mode_ff == MODE_ONESHOT);
  c_sweep: cover property (finish && mode_ff == MODE_SWEEP && grp_ff == 2'h3);
  c_rsweep_wrap: cover property (done && mode_ff == MODE_RSWEEP && last_ch);
  c_retrig: cover property ((state_ff == ST_CONV) && trig_sel_ff && trig_fall);

endmodule

/* design/adc_seq_pkg.sv */
// Shared constants and types for the converter mode sequencer
package adc_seq_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] IEN_OFS = 8'h08;
  localparam logic [7:0] ICLR_OFS = 8'h0c;
  localparam logic [7:0] BUSY_OFS = 8'h10;
  localparam logic [7:0] RES_BASE = 8'h20;
  localparam logic [7:0] RES_LAST = 8'h3c;

  // ****************************************
  // Control field positions
  // ****************************************
  localparam int MODE_LSB = 0;
  localparam int CH_LSB = 2;
  localparam int GRP_LSB = 5;
  localparam int START_BIT = 7;
  localparam int TRIG_BIT = 8;
  localparam int RES10_BIT = 9;
  localparam int DIV_LSB = 10;

  // ****************************************
  // Status and interrupt bits
  // ****************************************
  localparam int STAT_W = 2;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_OVR_BIT = 1;

  // ****************************************
  // Widths
  // ****************************************
  localparam int CH_W = 3;
  localparam int NUM_CH = 8;
  localparam int RES_W = 10;

  // ****************************************
  // Conversion timing in converter clock ticks
  // ****************************************
  localparam int CONV_CYC_8 = 49;
  localparam int CONV_CYC_10 = 59;
  localparam int BITS_8 = 8;
  localparam int BITS_10 = 10;
  localparam int TRIAL_GAP = 3;
  localparam logic [6:0] LAST_TICK_8 = 7'(CONV_CYC_8 - 1);
  localparam logic [6:0] LAST_TICK_10 = 7'(CONV_CYC_10 - 1);
  localparam logic [6:0] SAR_T0_8 = 7'(CONV_CYC_8 - 1 - TRIAL_GAP * BITS_8);
  localparam logic [6:0] SAR_T0_10 = 7'(CONV_CYC_10 - 1 - TRIAL_GAP * BITS_10);
  localparam logic [3:0] LAST_BIT_8 = 4'(BITS_8 - 1);
  localparam logic [3:0] LAST_BIT_10 = 4'(BITS_10 - 1);
  localparam logic [1:0] DECIDE_SUB = 2'(TRIAL_GAP - 1);

  // ****************************************
  // Converter clock divide selections
  // ****************************************
  localparam logic [1:0] DIV1_LIM = 2'h0;
  localparam logic [1:0] DIV2_LIM = 2'h1;
  localparam logic [1:0] DIV4_LIM = 2'h3;

  typedef enum logic [1:0] {
    MODE_ONESHOT = 2'h0,
    MODE_REPEAT = 2'h1,
    MODE_SWEEP = 2'h2,
    MODE_RSWEEP = 2'h3
  } mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WAIT = 3'h2,
    ST_CONV = 3'h4
  } state_t;

endpackage

/* design/conv_clk_div.sv */
// Converter clock tick generator dividing the main clock
`timescale 1ns/1ps
module conv_clk_div
  import adc_seq_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [1:0] div_sel,
  output logic tick
);

  logic [1:0] cnt_ff;
  logic [1:0] lim;

  always_comb
  begin
    if (div_sel == 2'h0)
      lim = DIV1_LIM;
    else if (div_sel == 2'h1)
      lim = DIV2_LIM;
    else
      lim = DIV4_LIM;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_ff <= 2'h0;
    else if (cnt_ff >= lim)
      cnt_ff <= 2'h0;
    else
      cnt_ff <= cnt_ff + 2'h1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tick <= 1'b0;
    else
      tick <= (cnt_ff >= lim);
  end

endmodule

/* design/result_mem.sv */
// Per-channel result store with registered read port
`timescale 1ns/1ps
module result_mem
  import adc_seq_pkg::*;
(
  input wire logic hclk,
  input wire logic we,
  input wire logic [CH_W-1:0] waddr,
  input wire logic [RES_W-1:0] wdata,
  input wire logic [CH_W-1:0] raddr,
  output logic [RES_W-1:0] rdata_ff
);

  logic [RES_W-1:0] mem [NUM_CH];

  always_ff @(posedge hclk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  always_ff @(posedge hclk)
  begin
    rdata_ff <= mem[raddr];
  end

endmodule

/* verif/analog_front.sv */
// Comparator and input multiplexer model facing the sequencer
`timescale 1ns/1ps
module analog_front
  import adc_seq_pkg::*;
(
  input wire logic hclk,
  input wire logic slow,
  input wire logic [CH_W-1:0] analog_sel,
  input wire logic [RES_W-1:0] dac_code,
  input wire logic [RES_W*NUM_CH-1:0] levels,
  output logic cmp_high
);
  logic cmp_now;
  logic cmp_ff;
  // Input at or above the trial code
  assign cmp_now = levels[analog_sel*RES_W +: RES_W] >= dac_code;
  always_ff @(posedge hclk)
  begin
    cmp_ff <= cmp_now;
  end
  // Slow answer lags one cycle
  assign cmp_high = slow ? cmp_ff : cmp_now;
endmodule

/* verif/tb_top.sv */
// Self-checking bench for the converter mode sequencer
`timescale 1ns/1ps
module tb_top
  import adc_seq_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic ext_trig = 1'b1;
  logic slow = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [RES_W*NUM_CH-1:0] levels = '0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic irq;
  logic cmp_high;
  logic [CH_W-1:0] analog_sel;
  logic sample_en;
  logic se_q = 1'b0;
  logic [RES_W-1:0] dac_code;
  logic cclk;
  logic [31:0] rd;
  logic [CH_W-1:0] seen[$];
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  int n_tick = 0;
  int tk0;

  always #2.5 hclk = ~hclk;

  adc_mode_sequencer i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .irq(irq), .external_trigger_input(ext_trig),
    .cmp_high(cmp_high), .analog_sel(analog_sel), .sample_en(sample_en),
    .dac_code(dac_code), .converter_clock(cclk)
  );

  analog_front i_afe (
    .hclk(hclk), .slow(slow), .analog_sel(analog_sel), .dac_code(dac_code),
    .levels(levels), .cmp_high(cmp_high)
  );

  // ****************************************
  // Monitor and timeout
  // ****************************************
  always @(posedge hclk)
  begin
    se_q <= sample_en;
    if (cclk === 1'b1)
      n_tick++;
    if (sample_en === 1'b1 && se_q !== 1'b1)
      seen.push_back(analog_sel);
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      results();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen_v, input logic [31:0] exp);
    cmp_count++;
    if (seen_v !== exp)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen_v);
    end
  endtask

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(nm, rd, exp);
    chk("hresp", hresp, 0);
  endtask

  task automatic wait_irq();
    n = 0;
    while (irq !== 1'b1 && n < 5000)
    begin
      @(negedge hclk);
      n++;
    end
  endtask

  task automatic clr();
    wr(ICLR_OFS, 32'h3);
    @(negedge hclk);
    chk("irq_clear", irq, 0);
  endtask

  task automatic wait_conv(input int k);
    while (seen.size() < k)
      @(negedge hclk);
  endtask

  function automatic logic [31:0] ctrl(input int m, c, g, s, t, r, dv);
    return (m << MODE_LSB) | (c << CH_LSB) | (g << GRP_LSB) | (s << START_BIT) | (t << TRIG_BIT)
      | (r << RES10_BIT) | (dv << DIV_LSB);
  endfunction

  function automatic logic [RES_W-1:0] lv(input int c, input int g);
    return RES_W'(37 + c * 113 + g * 71);
  endfunction

  function automatic logic [31:0] res(input int c);
    return RES_BASE + 8'(4 * c);
  endfunction

  task automatic set_lv(input int g);
    for (int c = 0; c < NUM_CH; c++)
      levels[c*RES_W +: RES_W] = lv(c, g);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    set_lv(0);
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rdc("ctrl", CTRL_OFS, 0);
    rdc("stat", STAT_OFS, 0);
    rdc("ien", IEN_OFS, 0);
    rdc("busy", BUSY_OFS, 1);
    rdc("iclr", ICLR_OFS, 0);
    rdc("unmapped", 8'h40, 0);
    wr(IEN_OFS, 32'h1);
    rdc("ien", IEN_OFS, 1);
    for (int c = 0; c < NUM_CH; c++)
    begin
      seen.delete();
      wr(CTRL_OFS, ctrl(0, c, 0, 1, 0, 0, 0));
      wait_irq();
      chk("conv_time", 32'(n >= 48 && n <= 56), 1);
      chk("conv_count", seen.size(), 1);
      chk("conv_ch", seen[0], c);
      rdc("result", res(c), 32'(lv(c, 0) >> 2));
      rdc("ctrl_end", CTRL_OFS, ctrl(0, c, 0, 0, 0, 0, 0));
      rdc("stat_done", STAT_OFS, 1);
      clr();
    end
    slow <= 1'b1;
    wr(CTRL_OFS, ctrl(0, 6, 0, 1, 0, 1, 2));
    @(negedge hclk);
    tk0 = n_tick;
    wait_irq();
    chk("conv_time10", 32'(n >= 232 && n <= 252), 1);
    chk("ticks10", n_tick - tk0, CONV_CYC_10);
    rdc("result10", res(6), 32'(lv(6, 0)));
    wr(IEN_OFS, 32'h0);
    @(negedge hclk);
    chk("irq_masked", irq, 0);
    wr(IEN_OFS, 32'h1);
    @(negedge hclk);
    chk("irq_enabled", irq, 1);
    clr();
    slow <= 1'b0;
    set_lv(1);
    seen.delete();
    wr(CTRL_OFS, ctrl(1, 3, 0, 1, 0, 0, 0));
    wait_conv(3);
    chk("rep_ch", seen[2], 3);
    rdc("rep_result", res(3), 32'(lv(3, 1) >> 2));
    rdc("rep_start", CTRL_OFS, ctrl(1, 3, 0, 1, 0, 0, 0));
    chk("rep_irq", irq, 0);
    wr(CTRL_OFS, ctrl(1, 3, 0, 1, 0, 0, 0));
    rdc("stat_hazard", STAT_OFS, 2);
    wr(CTRL_OFS, ctrl(1, 3, 0, 0, 0, 0, 0));
    rdc("busy_stop", BUSY_OFS, 32'h31);
    clr();
    for (int g = 0; g < 4; g++)
    begin
      set_lv(2 + g);
      seen.delete();
      wr(CTRL_OFS, ctrl(2, 0, g, 1, 0, 0, 0));
      wait_irq();
      chk("sweep_count", seen.size(), 2 * (g + 1));
      for (int k = 0; k < 2 * (g + 1); k++)
      begin
        chk("sweep_ch", seen[k], k);
        rdc("sweep_result", res(k), 32'(lv(k, 2 + g) >> 2));
      end
      rdc("sweep_end", CTRL_OFS, ctrl(2, 0, g, 0, 0, 0, 0));
      clr();
    end
    set_lv(6);
    seen.delete();
    wr(CTRL_OFS, ctrl(3, 0, 1, 1, 0, 0, 0));
    wait_conv(9);
    for (int k = 4; k < 9; k++)
      chk("rsweep_ch", seen[k], k % 4);
    chk("rsweep_irq", irq, 0);
    rdc("rsweep_start", CTRL_OFS, ctrl(3, 0, 1, 1, 0, 0, 0));
    rdc("rsweep_result", res(2), 32'(lv(2, 6) >> 2));
    wr(CTRL_OFS, ctrl(3, 0, 1, 0, 0, 0, 0));
    clr();
    set_lv(7);
    wr(CTRL_OFS, ctrl(0, 2, 0, 1, 1, 0, 0));
    rdc("trig_armed", BUSY_OFS, 2);
    for (int t = 0; t < 2; t++)
    begin
      seen.delete();
      @(posedge hclk);
      ext_trig <= 1'b0;
      wait_irq();
      chk("trig_count", seen.size(), 1);
      rdc("trig_result", res(2), 32'(lv(2, 7) >> 2));
      rdc("trig_start", CTRL_OFS, ctrl(0, 2, 0, 1, 1, 0, 0));
      clr();
      @(posedge hclk);
      ext_trig <= 1'b1;
    end
    seen.delete();
    @(posedge hclk);
    ext_trig <= 1'b0;
    repeat (40) @(posedge hclk);
    ext_trig <= 1'b1;
    @(posedge hclk);
    ext_trig <= 1'b0;
    wait_irq();
    chk("retrig_count", seen.size(), 2);
    chk("retrig_time", 32'(n >= 45 && n <= 60), 1);
    clr();
    @(posedge hclk);
    ext_trig <= 1'b1;
    wr(CTRL_OFS, ctrl(0, 2, 0, 0, 1, 0, 0));
    rdc("trig_stop", BUSY_OFS, 32'h21);
    results();
  end
endmodule
